//--- hdl/smc_pkg.sv
// Constants, encodings and carrier structs for the serial master controller.
// Assumes a single 50 MHz clock and plain configuration ports.
package smc_pkg;

	localparam int unsigned CLK_HZ          = 50000000;
	localparam int unsigned LINK_MAX_HZ     = 25000000;
	localparam int unsigned MIN_HALF_CYCLES = (CLK_HZ + 2 * LINK_MAX_HZ - 1) / (2 * LINK_MAX_HZ);
	localparam int unsigned FIFO_DEPTH      = 8;
	localparam int unsigned LVL_W           = 4;
	localparam int unsigned DATA_W          = 16;
	localparam int unsigned CS_W            = 16;
	localparam int unsigned DIV_W           = 16;
	localparam int unsigned CNT_W           = 16;
	localparam logic [4:0]  FRAME_MIN       = 5'h04;
	localparam logic [4:0]  FRAME_MAX       = 5'h10;
	localparam logic [1:0]  OWNER_MASTER    = 2'h2;
	localparam logic [4:0]  IRQ_MASK_RESET  = 5'h1F;
	localparam int unsigned IRQ_RXF         = 0;
	localparam int unsigned IRQ_RXO         = 1;
	localparam int unsigned IRQ_RXU         = 2;
	localparam int unsigned IRQ_TXO         = 3;
	localparam int unsigned IRQ_TXE         = 4;

	typedef enum logic [1:0] {
		SMC_TRANSFER_MODE_TXRX,
		SMC_TRANSFER_MODE_TX,
		SMC_TRANSFER_MODE_RX,
		SMC_TRANSFER_MODE_RSVD
	} smc_transfer_mode_e;

	typedef struct packed {
		logic [3:0] frame_size_m1;
		smc_transfer_mode_e  transfer_mode;
		logic       frame_format;
		logic       clock_phase;
		logic       clock_polarity;
	} smc_config_s;

	typedef struct packed {
		logic tx_empty;
		logic tx_not_full;
		logic rx_full;
		logic rx_not_empty;
		logic busy;
	} smc_status_s;

endpackage

//--- hdl/smc_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and a fill level.
// Assumes one clock; the caller never pushes while full without noting overflow.
`timescale 1ns/100ps
module smc_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 8,
	parameter int unsigned LW    = 4
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic      [LW-1:0]    level
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign in_ready  = (level != LW'(DEPTH));
	assign out_valid = (level != '0);
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			level <= level + LW'(push) - LW'(pop);
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule

//--- hdl/smc_top.sv
// Serial master controller: FIFOs, link engine, status and interrupt sources.
// Assumes configuration ports are steady while the controller is enabled.
`timescale 1ns/100ps
module smc_top (
	input  wire logic                        clk,
	input  wire logic                        resetn,
	input  wire logic                        controller_enable,
	input  wire smc_pkg::smc_config_s        transaction_config,
	input  wire logic                        sync_frame_format_enable,
	input  wire logic [1:0]                  interface_owner,
	input  wire logic [smc_pkg::CNT_W-1:0]   frame_count,
	input  wire logic [smc_pkg::CS_W-1:0]    slave_select,
	input  wire logic [smc_pkg::DIV_W-1:0]   clock_divider,
	input  wire logic [smc_pkg::LVL_W-1:0]   tx_threshold,
	input  wire logic [smc_pkg::LVL_W-1:0]   rx_threshold,
	input  wire logic [4:0]                  irq_mask,
	input  wire logic                        data_write,
	input  wire logic [smc_pkg::DATA_W-1:0]  data_wdata,
	input  wire logic                        data_read,
	output logic      [smc_pkg::DATA_W-1:0]  data_rdata,
	input  wire logic                        tx_overflow_clear,
	input  wire logic                        rx_overflow_clear,
	input  wire logic                        rx_underflow_clear,
	output smc_pkg::smc_status_s             status_reg,
	output logic      [smc_pkg::LVL_W-1:0]   tx_fill_level,
	output logic      [smc_pkg::LVL_W-1:0]   rx_fill_level,
	output logic      [4:0]                  irq_raw,
	output logic      [4:0]                  irq_active,
	output logic                             irq,
	output logic                             serial_clk,
	output logic                             serial_data_out,
	input  wire logic                        serial_data_in,
	output logic      [smc_pkg::CS_W-1:0]    chip_select_n
);
	import smc_pkg::*;

	// ----------------------------------------------------------------
	// Configuration capture
	// ----------------------------------------------------------------
	smc_config_s cfg;
	logic [CS_W-1:0] cfg_cs;
	logic [DIV_W-1:0] cfg_div;
	logic [CNT_W-1:0] cfg_cnt;
	logic cfg_ssp;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg     <= '0;
			cfg_cs  <= '0;
			cfg_div <= '0;
			cfg_cnt <= '0;
			cfg_ssp <= 1'b0;
		end else if (!controller_enable) begin
			cfg     <= transaction_config;
			cfg_cs  <= slave_select;
			cfg_div <= clock_divider;
			cfg_cnt <= frame_count;
			cfg_ssp <= transaction_config.frame_format && sync_frame_format_enable;
		end
	end

	function automatic logic [4:0] frame_bits(input logic [3:0] m1);
		logic [4:0] n;
		n = {1'b0, m1} + 5'h01;
		frame_bits = (n < FRAME_MIN) ? FRAME_MIN : n;
	endfunction

	wire [4:0]       nbits   = frame_bits(cfg.frame_size_m1);
	wire [DATA_W-1:0] fmask  = DATA_W'((17'h00001 << nbits) - 17'h00001);
	wire             owned   = (interface_owner == OWNER_MASTER);
	wire             active  = controller_enable && owned;
	wire [DIV_W-1:0] half_lim = (cfg_div < DIV_W'(MIN_HALF_CYCLES)) ?
		DIV_W'(MIN_HALF_CYCLES) : cfg_div;
	wire             cpol    = cfg_ssp ? 1'b0 : cfg.clock_polarity;
	wire             cpha    = cfg_ssp ? 1'b0 : cfg.clock_phase;

	// ----------------------------------------------------------------
	// FIFOs
	// ----------------------------------------------------------------
	logic             tx_in_ready;
	logic             tx_valid;
	logic             tx_pop;
	logic [DATA_W-1:0] tx_data;
	logic [LVL_W-1:0] tx_lvl;
	logic             rx_in_ready;
	logic             rx_push;
	logic [DATA_W-1:0] rx_word;
	logic             rx_valid;
	logic [DATA_W-1:0] rx_data;
	logic [LVL_W-1:0] rx_lvl;
	wire              rx_pop = data_read && rx_valid;

	smc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .LW(LVL_W)) u_tx (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (data_write),
		.in_ready  (tx_in_ready),
		.in_data   (data_wdata & fmask),
		.out_valid (tx_valid),
		.out_ready (tx_pop),
		.out_data  (tx_data),
		.level     (tx_lvl)
	);

	smc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .LW(LVL_W)) u_rx (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (rx_push),
		.in_ready  (rx_in_ready),
		.in_data   (rx_word),
		.out_valid (rx_valid),
		.out_ready (rx_pop),
		.out_data  (rx_data),
		.level     (rx_lvl)
	);

	// ----------------------------------------------------------------
	// Link engine
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {SMC_IDLE, SMC_LEAD, SMC_SHIFT} smc_state_e;
	smc_state_e state;
	logic [DIV_W-1:0] div_cnt;
	logic             phase;
	logic [4:0]       bit_cnt;
	logic [DATA_W-1:0] shreg;
	logic [DATA_W-1:0] rxsh;
	logic [CNT_W-1:0] rx_left;
	logic             rx_only;
	logic             sample_q;
	logic             push_q;

	wire tick      = (div_cnt == half_lim - 1'b1);
	wire last_bit  = (bit_cnt == nbits - 5'h01);
	wire frame_end = (state == SMC_SHIFT) && tick && phase && last_bit;
	wire more_tx   = !rx_only && tx_valid;
	wire more_rx   = rx_only && (rx_left != CNT_W'(1));
	wire keep_on   = more_tx || more_rx;
	wire start     = (state == SMC_IDLE) && active && tx_valid;
	wire sample_now = (state == SMC_SHIFT) && tick && !phase;

	assign tx_pop  = start || (frame_end && more_tx);
	wire   next_push = frame_end && (cfg.transfer_mode != SMC_TRANSFER_MODE_TX);
	assign rx_push   = push_q;
	assign rx_word   = rxsh & fmask;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state   <= SMC_IDLE;
			div_cnt <= '0;
			phase   <= 1'b0;
			bit_cnt <= '0;
			shreg   <= '0;
			rx_left <= '0;
			rx_only <= 1'b0;
		end else if (!active) begin
			state   <= SMC_IDLE;
			div_cnt <= '0;
		end else begin
			div_cnt <= (state == SMC_IDLE || tick) ? '0 : div_cnt + 1'b1;
			case (state)
				SMC_IDLE: begin
					phase   <= 1'b0;
					bit_cnt <= '0;
					if (start) begin
						rx_only <= (cfg.transfer_mode == SMC_TRANSFER_MODE_RX);
						rx_left <= cfg_cnt + 1'b1;
						shreg   <= tx_data << (5'h10 - nbits);
						state   <= SMC_LEAD;
					end
				end
				SMC_LEAD: begin
					if (tick) begin
						state <= SMC_SHIFT;
					end
				end
				SMC_SHIFT: begin
					if (tick) begin
						phase <= !phase;
						if (phase && !last_bit) begin
							bit_cnt <= bit_cnt + 5'h01;
							shreg   <= shreg << 1;
						end
						if (frame_end) begin
							bit_cnt <= '0;
							if (rx_only) begin
								rx_left <= rx_left - 1'b1;
							end
							if (more_tx) begin
								shreg <= tx_data << (5'h10 - nbits);
							end
							if (!keep_on) begin
								state <= SMC_IDLE;
							end
						end
					end
				end
				default: state <= SMC_IDLE;
			endcase
		end
	end

	// The pins lag the engine by one register, so sampling waits one cycle.
	// The frame is pushed one cycle after its end, once the last bit is in.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sample_q <= 1'b0;
			push_q   <= 1'b0;
			rxsh     <= '0;
		end else begin
			sample_q <= sample_now;
			push_q   <= next_push;
			if (sample_q) begin
				rxsh <= {rxsh[DATA_W-2:0], serial_data_in};
			end
		end
	end

	// ----------------------------------------------------------------
	// Pins
	// ----------------------------------------------------------------
	wire in_xfer = (state != SMC_IDLE);
	wire clk_lvl = (state == SMC_SHIFT) ? (cpol ^ (phase ^ cpha)) : cpol;
	wire [CS_W-1:0] next_cs_n = in_xfer ? ~cfg_cs : {CS_W{1'b1}};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			serial_clk      <= 1'b0;
			serial_data_out <= 1'b0;
			chip_select_n   <= {CS_W{1'b1}};
		end else begin
			serial_clk      <= clk_lvl;
			serial_data_out <= in_xfer && !rx_only && shreg[DATA_W-1];
			chip_select_n   <= next_cs_n;
		end
	end

	// ----------------------------------------------------------------
	// Status and interrupt sources
	// ----------------------------------------------------------------
	logic rx_overflow_irq;
	logic rx_underflow_irq;
	logic tx_overflow_irq;
	wire  ev_txo = data_write && !tx_in_ready;
	wire  ev_rxo = rx_push && !rx_in_ready;
	wire  ev_rxu = data_read && !rx_valid;
	wire [4:0] next_raw = {tx_lvl < tx_threshold, tx_overflow_irq, rx_underflow_irq, rx_overflow_irq,
		rx_lvl > rx_threshold};
	wire [4:0] next_act = next_raw & irq_mask;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_overflow_irq <= 1'b0;
			rx_underflow_irq <= 1'b0;
			tx_overflow_irq <= 1'b0;
		end else begin
			rx_overflow_irq <= ev_rxo || (rx_overflow_irq && !rx_overflow_clear);
			rx_underflow_irq <= ev_rxu || (rx_underflow_irq && !rx_underflow_clear);
			tx_overflow_irq <= ev_txo || (tx_overflow_irq && !tx_overflow_clear);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_raw       <= '0;
			irq_active    <= '0;
			irq           <= 1'b0;
			status_reg    <= '0;
			tx_fill_level <= '0;
			rx_fill_level <= '0;
			data_rdata    <= '0;
		end else begin
			irq_raw       <= next_raw;
			irq_active    <= next_act;
			irq           <= controller_enable && (next_act != '0);
			status_reg    <= '{tx_empty: !tx_valid, tx_not_full: tx_in_ready,
				rx_full: !rx_in_ready, rx_not_empty: rx_valid, busy: in_xfer};
			tx_fill_level <= tx_lvl;
			rx_fill_level <= rx_lvl;
			if (rx_pop) begin
				data_rdata <= rx_data;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_cs_idle;
		@(posedge clk) disable iff (!resetn)
		(state == SMC_IDLE) |=> (chip_select_n == {CS_W{1'b1}});
	endproperty
	a_cs_idle: assert property (p_cs_idle) else $error("select low while idle");

	property p_cs_hold;
		@(posedge clk) disable iff (!resetn)
		(frame_end && keep_on && active) |=> ##1 (chip_select_n == ~cfg_cs);
	endproperty
	a_cs_hold: assert property (p_cs_hold) else $error("select dropped between frames");

	property p_txo;
		@(posedge clk) disable iff (!resetn)
		ev_txo |=> tx_overflow_irq ##1 irq_raw[IRQ_TXO];
	endproperty
	a_txo: assert property (p_txo) else $error("tx overflow not flagged");

	property p_rxu;
		@(posedge clk) disable iff (!resetn)
		(rx_underflow_irq && !rx_underflow_clear && !ev_rxu) |=> rx_underflow_irq;
	endproperty
	a_rxu: assert property (p_rxu) else $error("rx underflow lost");

	property p_rxo;
		@(posedge clk) disable iff (!resetn)
		(rx_overflow_clear && !ev_rxo) |=> !rx_overflow_irq;
	endproperty
	a_rxo: assert property (p_rxo) else $error("rx overflow not cleared");

	property p_rxf;
		@(posedge clk) disable iff (!resetn)
		1'b1 |=> (irq_raw[IRQ_RXF] == ($past(rx_lvl) > $past(rx_threshold)));
	endproperty
	a_rxf: assert property (p_rxf) else $error("rx threshold wrong");

	property p_txe;
		@(posedge clk) disable iff (!resetn)
		1'b1 |=> (irq_raw[IRQ_TXE] == ($past(tx_lvl) < $past(tx_threshold)));
	endproperty
	a_txe: assert property (p_txe) else $error("tx threshold wrong");

	property p_irq;
		@(posedge clk) disable iff (!resetn)
		irq |-> ((irq_active != '0) && $past(controller_enable));
	endproperty
	a_irq: assert property (p_irq) else $error("irq without source");

	property p_txonly;
		@(posedge clk) disable iff (!resetn)
		(cfg.transfer_mode == SMC_TRANSFER_MODE_TX) |-> !rx_push;
	endproperty
	a_txonly: assert property (p_txonly) else $error("rx push in tx only");

	property p_rate;
		@(posedge clk) disable iff (!resetn)
		($changed(serial_clk) && (half_lim > DIV_W'(MIN_HALF_CYCLES))) |=> $stable(serial_clk);
	endproperty
	a_rate: assert property (p_rate) else $error("link clock too fast");

	c_frame: cover property (@(posedge clk) disable iff (!resetn) frame_end);
	c_multi: cover property (@(posedge clk) disable iff (!resetn) frame_end && keep_on);
	c_rxonly: cover property (@(posedge clk) disable iff (!resetn) rx_push && rx_only);
	c_irq: cover property (@(posedge clk) disable iff (!resetn) irq);
endmodule

//--- dv/smc_slave_model.sv
// Behavioural serial slave that loops data back and measures the link.
// Assumes it answers on whichever chip selects are driven low.
`timescale 1ns/100ps
module smc_slave_model (
	input  wire logic        clr,
	input  wire logic        serial_clk,
	input  wire logic        serial_data_out,
	input  wire logic [15:0] chip_select_n,
	output logic             serial_data_in,
	output int               edges,
	output int               deselects,
	output logic      [15:0] cs_seen,
	output realtime          min_half
);
	logic    sel;
	logic    sel_late;
	realtime last_t;

	assign sel = ~&chip_select_n;
	// The delayed select keeps a clock edge that lands on the deselect itself.
	assign #1 sel_late = sel;
	// Data is looped back while selected; a released line shows the inverse.
	assign serial_data_in = sel ? serial_data_out : ~serial_data_out;

	always @(posedge clr) begin
		edges = 0;
		deselects = 0;
		min_half = 1.0e9;
		last_t = $realtime;
	end
	always @(serial_clk) begin
		if (sel || sel_late) begin
			edges++;
			if ($realtime - last_t < min_half) begin
				min_half = $realtime - last_t;
			end
			last_t = $realtime;
		end
	end
	always @(chip_select_n) begin
		if (~&chip_select_n) begin
			cs_seen = chip_select_n;
		end
	end
	always @(negedge sel) begin
		deselects++;
	end
endmodule

//--- dv/testbench.sv
// Self-checking bench for the serial master controller with a looped-back slave.
// Assumes the design package and the slave model are compiled first.
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
	$display("[FAIL] %0t got %h expected %h", $time, (a), (b)); end end
module testbench;
	import smc_pkg::*;
	logic        clk, resetn, en, sync_en, dw, dr, txo_clr, rxo_clr, rxu_clr, clr, irq;
	logic        sclk, mosi, miso;
	smc_config_s cfg;
	smc_status_s st;
	logic [1:0]  owner;
	logic [15:0] fcount, ssel, div, wdata, rdata, csn, cs_seen, d;
	logic [3:0]  txthr, rxthr, txlvl, rxlvl;
	logic [4:0]  mask, raw, act;
	int          edges, desel, failures, checks, cur_fs, n;
	realtime     min_half;
	logic [15:0] sent[$];

	smc_top smc_top_i (.clk(clk), .resetn(resetn), .controller_enable(en),
		.transaction_config(cfg), .sync_frame_format_enable(sync_en),
		.interface_owner(owner), .frame_count(fcount), .slave_select(ssel),
		.clock_divider(div), .tx_threshold(txthr), .rx_threshold(rxthr), .irq_mask(mask),
		.data_write(dw), .data_wdata(wdata), .data_read(dr), .data_rdata(rdata),
		.tx_overflow_clear(txo_clr), .rx_overflow_clear(rxo_clr),
		.rx_underflow_clear(rxu_clr), .status_reg(st), .tx_fill_level(txlvl),
		.rx_fill_level(rxlvl), .irq_raw(raw), .irq_active(act), .irq(irq),
		.serial_clk(sclk), .serial_data_out(mosi), .serial_data_in(miso),
		.chip_select_n(csn));
	smc_slave_model smc_slave_model_i (.clr(clr), .serial_clk(sclk), .serial_data_out(mosi),
		.chip_select_n(csn), .serial_data_in(miso), .edges(edges), .deselects(desel),
		.cs_seen(cs_seen), .min_half(min_half));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	always #10 clk = ~clk;

	function automatic logic [15:0] fmask(input int fs);
		return 16'hFFFF >> (16 - fs);
	endfunction

	task cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task setup(input smc_transfer_mode_e m, input int fs, input logic ff);
		@(posedge clk);
		en <= 1'b0;
		clr <= 1'b1;
		cfg.frame_size_m1 <= 4'(fs - 1);
		cfg.transfer_mode <= m;
		cfg.frame_format <= ff;
		cfg.clock_phase <= ff ? 1'b0 : 1'($urandom);
		cfg.clock_polarity <= ff ? 1'b0 : 1'($urandom);
		ssel <= 16'(1 << $urandom_range(15));
		div <= 16'($urandom_range(3));
		cur_fs = fs;
		sent.delete();
		@(posedge clk);
		clr <= 1'b0;
		en <= 1'b1;
		cyc(1);
	endtask

	task push(input int k);
		for (int i = 0; i < k; i++) begin
			@(posedge clk);
			d = 16'($urandom);
			dw <= 1'b1;
			wdata <= d;
			sent.push_back(d & fmask(cur_fs));
		end
		@(posedge clk);
		dw <= 1'b0;
	endtask

	task pop(output logic [15:0] v);
		@(posedge clk);
		dr <= 1'b1;
		@(posedge clk);
		dr <= 1'b0;
		cyc(1);
		v = rdata;
	endtask

	task wait_idle;
		n = 0;
		cyc(4);
		while (!(st.tx_empty === 1'b1 && st.busy === 1'b0) && n < 20000) begin
			cyc(1);
			n++;
		end
		`CHK(n < 20000, 1'b1)
		cyc(2);
	endtask

	task clear_irq(input int k);
		@(posedge clk);
		txo_clr <= (k == IRQ_TXO);
		rxo_clr <= (k == IRQ_RXO);
		rxu_clr <= (k == IRQ_RXU);
		@(posedge clk);
		{txo_clr, rxo_clr, rxu_clr} <= 3'h0;
		cyc(3);
	endtask

	task wrap_up;
		if (failures == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		#1ms;
		failures++;
		wrap_up();
	end

	initial begin
		void'($urandom(32'hDE569CDC));
		{clk, resetn, en, sync_en, dw, dr, txo_clr, rxo_clr, rxu_clr, clr} = '0;
		cfg = '0;
		owner = 2'h0;
		fcount = 16'h0002;
		{ssel, div, wdata} = '0;
		txthr = 4'h4;
		rxthr = 4'h3;
		mask = 5'($urandom);
		failures = 0;
		checks = 0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		cyc(1);
		`CHK(csn, 16'hFFFF)
		// Pins not yet handed over: data queues but nothing moves.
		setup(SMC_TRANSFER_MODE_TXRX, 16, 1'b0);
		push(9);
		cyc(3);
		`CHK(txlvl, 4'h8)
		`CHK(st.tx_not_full, 1'b0)
		`CHK(csn, 16'hFFFF)
		`CHK(raw[IRQ_TXO], 1'b1)
		`CHK(raw[IRQ_TXE], 1'b0)
		`CHK(act, raw & mask)
		`CHK(irq, |(raw & mask))
		clear_irq(IRQ_TXO);
		`CHK(raw[IRQ_TXO], 1'b0)
		pop(d);
		cyc(1);
		`CHK(raw[IRQ_RXU], 1'b1)
		clear_irq(IRQ_RXU);
		`CHK(raw[IRQ_RXU], 1'b0)
		void'(sent.pop_back());
		@(posedge clk);
		owner <= 2'h2;
		wait_idle();
		`CHK(rxlvl, 4'h8)
		`CHK(st.rx_full, 1'b1)
		`CHK(raw[IRQ_RXF], 1'b1)
		`CHK(raw[IRQ_TXE], 1'b1)
		`CHK(desel, 1)
		push(1);
		wait_idle();
		`CHK(raw[IRQ_RXO], 1'b1)
		clear_irq(IRQ_RXO);
		`CHK(raw[IRQ_RXO], 1'b0)
		for (int i = 0; i < 8; i++) begin
			pop(d);
			`CHK(d, sent[i])
		end
		`CHK(rxlvl, 4'h0)
		`CHK(raw[IRQ_RXF], 1'b0)
		@(posedge clk);
		en <= 1'b0;
		cyc(2);
		`CHK(irq, 1'b0)
		// Every frame size, both transmitting modes, random phase and polarity unless the frame format bit is set.
		for (int fs = 4; fs <= 16; fs++) begin
			setup((fs % 2) ? SMC_TRANSFER_MODE_TX : SMC_TRANSFER_MODE_TXRX, fs, 1'(fs % 3 == 0));
			n = $urandom_range(1, 3);
			push(n);
			wait_idle();
			`CHK(edges, 2 * fs * sent.size())
			`CHK(desel, 1)
			`CHK(cs_seen, ~ssel)
			`CHK(min_half >= 20.0, 1'b1)
			if (fs % 2) begin
				`CHK(rxlvl, 4'h0)
			end else begin
				foreach (sent[i]) begin
					pop(d);
					`CHK(d, sent[i])
				end
			end
		end
		// Receive only: one dummy frame pulls in the counted frames.
		setup(SMC_TRANSFER_MODE_RX, 8, 1'b0);
		push(1);
		wait_idle();
		`CHK(rxlvl, 4'h3)
		`CHK(edges, 2 * 8 * 3)
		repeat (3) pop(d);
		// Synchronous frame format selected by both bits.
		sync_en <= 1'b1;
		setup(SMC_TRANSFER_MODE_TXRX, 6, 1'b1);
		push(2);
		wait_idle();
		`CHK(rxlvl, 4'h2)
		wrap_up();
	end
endmodule
